/* File: src/amt_top.sv */
// Alert masks, low-bit readings, pin config and overtemperature timer.
// Assumes a byte register port driven synchronously by the bus front end,
// status flags held by the status registers outside, and an active-low
// overtemperature pin already synchronous to clk_sys_in.
module amt_top
    import amt_pkg::*;
#(
    parameter int unsigned STEP_CYC = AMT_STEP_CYC,
    parameter int unsigned TACH_SLOW_CYC = AMT_TACH_SLOW_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic [7:0] status1_flags_in,
    input wire logic [7:0] status2_flags_in,
    input wire logic timer_event_clr_in,
    input wire logic fan4_is_overtemp_in,
    input wire logic overtemp_pin_n_in,
    input wire logic adc_update_in,
    input wire logic [3:0] volt_low_in,
    input wire logic [5:0] temp_low_in,
    input wire logic [4:0] hi_read_in,
    output logic alert_out,
    output logic alert_pin_oe_out,
    output logic second_pulse_is_alert_out,
    output logic fan_full_speed_out,
    output logic tach_fast_out,
    output logic [AMT_FANS-1:0] tach_continuous_out,
    output logic tach_meas_tick_out,
    output logic timer_event_out,
    output logic volt_frozen_out,
    output logic temp_frozen_out
);
    localparam int unsigned TACH_FAST_CYC = TACH_SLOW_CYC / AMT_TACH_SPEEDUP;

    // Register file
    logic [7:0] alert_mask_one;
    logic [7:0] alert_mask_two;
    logic [7:0] pin_and_tach_config;
    logic [7:0] overtemp_time_limit;
    logic [7:0] next_mask_one;
    logic [7:0] next_mask_two;
    logic [7:0] next_config;
    logic [7:0] next_limit;

    // Read port
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic [7:0] voltage_low_bits;
    logic [7:0] temperature_low_bits;
    logic [3:0] volt_low;
    logic [5:0] temp_low;
    logic rd_volt;
    logic rd_temp;
    logic rd_ot;

    // Overtemperature timer
    amt_ot_state_t ot_state;
    amt_ot_state_t next_ot_state;
    logic [31:0] step_cyc;
    logic [31:0] next_step_cyc;
    logic [7:0] assert_time_count;
    logic [7:0] next_assert_time_count;
    logic [7:0] overtemp_assert_time;
    logic [7:0] next_ot_status;
    logic ot_prev;
    logic next_ot_prev;
    logic limit_fired;
    logic next_limit_fired;
    logic next_timer_event;
    logic ot_now;
    logic ot_rise;
    logic fire;

    // Alert and pin outputs
    logic next_alert;
    logic next_alert_oe;
    logic [7:0] status2_eff;
    logic [7:0] s1_live;
    logic [7:0] s2_live;

    // Tachometer rate
    logic [31:0] tach_cnt;
    logic [31:0] next_tach_cnt;
    logic next_tach_tick;
    logic [31:0] tach_period;

    assign rd_volt = reg_rd_in && (reg_addr_in == AMT_ADDR_VOLT_LOW);
    assign rd_temp = reg_rd_in && (reg_addr_in == AMT_ADDR_TEMP_LOW);
    assign rd_ot = reg_rd_in && (reg_addr_in == AMT_ADDR_OT_TIME);

    amt_lsb_hold #(
        .CH(AMT_VOLT_CH)
    ) u_volt_hold (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .update_in(adc_update_in),
        .low_in(volt_low_in),
        .reg_read_in(rd_volt),
        .hi_read_in(hi_read_in[1:0]),
        .low_out(volt_low),
        .frozen_out(volt_frozen_out)
    );

    amt_lsb_hold #(
        .CH(AMT_TEMP_CH)
    ) u_temp_hold (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .update_in(adc_update_in),
        .low_in(temp_low_in),
        .reg_read_in(rd_temp),
        .hi_read_in(hi_read_in[4:2]),
        .low_out(temp_low),
        .frozen_out(temp_frozen_out)
    );

    assign voltage_low_bits =
        {2'b00, volt_low[3:2], 2'b00, volt_low[1:0]};
    assign temperature_low_bits = {temp_low, 2'b00};

    // Register writes
    always_comb begin
        next_mask_one = alert_mask_one;
        next_mask_two = alert_mask_two;
        next_config = pin_and_tach_config;
        next_limit = overtemp_time_limit;
        if (reg_wr_in) begin
            case (reg_addr_in)
                AMT_ADDR_MASK_ONE: begin
                    next_mask_one = reg_wdata_in;
                end
                AMT_ADDR_MASK_TWO: begin
                    next_mask_two = reg_wdata_in & AMT_M2_WR_BITS;
                end
                AMT_ADDR_CONFIG: begin
                    next_config = reg_wdata_in;
                end
                AMT_ADDR_OT_LIMIT: begin
                    next_limit = reg_wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            alert_mask_one <= AMT_RST_MASK;
            alert_mask_two <= AMT_RST_MASK;
            pin_and_tach_config <= AMT_RST_CONFIG;
            overtemp_time_limit <= AMT_RST_OT;
        end else begin
            alert_mask_one <= next_mask_one;
            alert_mask_two <= next_mask_two;
            pin_and_tach_config <= next_config;
            overtemp_time_limit <= next_limit;
        end
    end

    // Read data, answered one cycle after the strobe
    always_comb begin
        next_rvalid = reg_rd_in;
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            case (reg_addr_in)
                AMT_ADDR_MASK_ONE: next_rdata = alert_mask_one;
                AMT_ADDR_MASK_TWO: next_rdata = alert_mask_two;
                AMT_ADDR_VOLT_LOW: next_rdata = voltage_low_bits;
                AMT_ADDR_TEMP_LOW: next_rdata = temperature_low_bits;
                AMT_ADDR_CONFIG: next_rdata = pin_and_tach_config;
                AMT_ADDR_OT_TIME: next_rdata = overtemp_assert_time;
                AMT_ADDR_OT_LIMIT: next_rdata = overtemp_time_limit;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out <= next_rdata;
            reg_rvalid_out <= next_rvalid;
        end
    end

    // Overtemperature timer
    assign ot_now = !overtemp_pin_n_in && fan4_is_overtemp_in
        && pin_and_tach_config[AMT_CFG_MON_BIT];
    assign ot_rise = ot_now && !ot_prev;

    always_comb begin
        next_ot_state = ot_state;
        next_step_cyc = step_cyc;
        next_assert_time_count = assert_time_count;
        next_limit_fired = limit_fired;
        next_ot_prev = ot_now;
        fire = 1'b0;
        case (ot_state)
            AMT_OT_IDLE: begin
                next_step_cyc = 32'h0;
                next_limit_fired = 1'b0;
                if (ot_rise) begin
                    next_ot_state = AMT_OT_RUN;
                    next_assert_time_count = 8'h00;
                    // Zero limit fires at the assertion itself
                    if (overtemp_time_limit == 8'h00) begin
                        fire = 1'b1;
                        next_limit_fired = 1'b1;
                    end
                end
            end
            AMT_OT_RUN: begin
                if (!ot_now) begin
                    next_ot_state = AMT_OT_IDLE;
                end else if (step_cyc == STEP_CYC - 1) begin
                    next_step_cyc = 32'h0;
                    // Saturate rather than wrap past the longest time
                    if (assert_time_count != AMT_STEPS_MAX) begin
                        next_assert_time_count =
                            assert_time_count + 8'h01;
                    end
                end else begin
                    next_step_cyc = step_cyc + 32'h1;
                end
                if (ot_now && !limit_fired
                    && overtemp_time_limit != 8'h00
                    && assert_time_count >= overtemp_time_limit) begin
                    fire = 1'b1;
                    next_limit_fired = 1'b1;
                end
            end
            default: begin
                next_ot_state = AMT_OT_IDLE;
            end
        endcase

        // Read clears, but a live assertion sets again in the same cycle
        next_ot_status = overtemp_assert_time;
        if (rd_ot) begin
            next_ot_status = 8'h00;
        end
        if (ot_now) begin
            if (ot_state == AMT_OT_RUN
                && assert_time_count >= AMT_SHOW_STEPS) begin
                next_ot_status = assert_time_count;
            end else begin
                next_ot_status[0] = 1'b1;
            end
        end
        next_timer_event = (timer_event_out && !timer_event_clr_in)
            || fire;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ot_state <= AMT_OT_IDLE;
            step_cyc <= 32'h0;
            assert_time_count <= 8'h00;
            overtemp_assert_time <= AMT_RST_OT;
            ot_prev <= 1'b0;
            limit_fired <= 1'b0;
            timer_event_out <= 1'b0;
        end else begin
            ot_state <= next_ot_state;
            step_cyc <= next_step_cyc;
            assert_time_count <= next_assert_time_count;
            overtemp_assert_time <= next_ot_status;
            ot_prev <= next_ot_prev;
            limit_fired <= next_limit_fired;
            timer_event_out <= next_timer_event;
        end
    end

    // Alert gating
    always_comb begin
        status2_eff = status2_flags_in;
        // Fan 4 bit carries the timer event in overtemperature mode
        status2_eff[AMT_M2_FAN4_BIT] = fan4_is_overtemp_in ?
            timer_event_out : status2_flags_in[AMT_M2_FAN4_BIT];
        s1_live = status1_flags_in & AMT_M1_CHANNELS & ~alert_mask_one;
        s2_live = status2_eff & ~alert_mask_two;
        if (alert_mask_one[AMT_M1_STATUS2_BIT]) begin
            s2_live = 8'h00;
        end
        next_alert = (|s1_live) || (|s2_live);
        next_alert_oe = next_alert
            && pin_and_tach_config[AMT_CFG_ALERT_BIT];
    end

    // Tachometer measurement rate
    assign tach_period = pin_and_tach_config[AMT_CFG_FAST_BIT] ?
        TACH_FAST_CYC : TACH_SLOW_CYC;
    always_comb begin
        next_tach_tick = 1'b0;
        next_tach_cnt = tach_cnt + 32'h1;
        // Shortening the period mid-count restarts at once, not a wrap
        if (tach_cnt >= tach_period - 1) begin
            next_tach_cnt = 32'h0;
            next_tach_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            alert_out <= 1'b0;
            alert_pin_oe_out <= 1'b0;
            second_pulse_is_alert_out <= 1'b0;
            fan_full_speed_out <= 1'b0;
            tach_fast_out <= 1'b0;
            tach_continuous_out <= '0;
            tach_meas_tick_out <= 1'b0;
            tach_cnt <= 32'h0;
        end else begin
            alert_out <= next_alert;
            alert_pin_oe_out <= next_alert_oe;
            second_pulse_is_alert_out <=
                next_config[AMT_CFG_ALERT_BIT];
            fan_full_speed_out <= ot_now
                && pin_and_tach_config[AMT_CFG_BOOST_BIT];
            tach_fast_out <= next_config[AMT_CFG_FAST_BIT];
            tach_continuous_out <=
                next_config[AMT_CFG_CONT_LSB +: AMT_FANS];
            tach_meas_tick_out <= next_tach_tick;
            tach_cnt <= next_tach_cnt;
        end
    end
endmodule : amt_top

/* File: src/amt_pkg.sv */
// Constants for the alert mask and overtemperature timer register group.
// Assumes a 100 MHz system clock and a byte-wide register port.
package amt_pkg;
    localparam logic [7:0] AMT_ADDR_MASK_ONE = 8'h74;
    localparam logic [7:0] AMT_ADDR_MASK_TWO = 8'h75;
    localparam logic [7:0] AMT_ADDR_VOLT_LOW = 8'h76;
    localparam logic [7:0] AMT_ADDR_TEMP_LOW = 8'h77;
    localparam logic [7:0] AMT_ADDR_CONFIG = 8'h78;
    localparam logic [7:0] AMT_ADDR_OT_TIME = 8'h79;
    localparam logic [7:0] AMT_ADDR_OT_LIMIT = 8'h7A;

    localparam logic [7:0] AMT_RST_MASK = 8'h00;
    localparam logic [7:0] AMT_RST_CONFIG = 8'h00;
    localparam logic [7:0] AMT_RST_OT = 8'h00;

    // Channel bits in mask one and in the first status group
    localparam logic [7:0] AMT_M1_CHANNELS = 8'h75;
    localparam int AMT_M1_STATUS2_BIT = 7;
    // Writable bits of mask two; bit 1 is read-only
    localparam logic [7:0] AMT_M2_WR_BITS = 8'hFD;
    localparam int AMT_M2_FAN4_BIT = 5;

    localparam int AMT_CFG_ALERT_BIT = 0;
    localparam int AMT_CFG_MON_BIT = 1;
    localparam int AMT_CFG_BOOST_BIT = 2;
    localparam int AMT_CFG_FAST_BIT = 3;
    localparam int AMT_CFG_CONT_LSB = 4;
    localparam int AMT_FANS = 4;

    // Channel counts of the voltage and temperature high-byte read strobes
    localparam int AMT_VOLT_CH = 2;
    localparam int AMT_TEMP_CH = 3;

    localparam int unsigned AMT_CLK_PERIOD_NS = 10;
    localparam int unsigned AMT_STEP_US = 22760;
    localparam int unsigned AMT_SHOW_US = 45520;
    localparam int unsigned AMT_TACH_SLOW_MS = 1000;
    localparam int unsigned AMT_TACH_FAST_MS = 250;
    localparam int unsigned AMT_STEP_CYC =
        AMT_STEP_US * 1000 / AMT_CLK_PERIOD_NS;
    localparam logic [7:0] AMT_SHOW_STEPS =
        8'(AMT_SHOW_US / AMT_STEP_US);
    localparam int unsigned AMT_TACH_SLOW_CYC =
        AMT_TACH_SLOW_MS * 1000000 / AMT_CLK_PERIOD_NS;
    localparam int unsigned AMT_TACH_SPEEDUP =
        AMT_TACH_SLOW_MS / AMT_TACH_FAST_MS;
    localparam logic [7:0] AMT_STEPS_MAX = 8'hFF;

    typedef enum logic [0:0] {
        AMT_OT_IDLE = 1'b0,
        AMT_OT_RUN = 1'b1
    } amt_ot_state_t;
endpackage : amt_pkg

/* File: src/amt_lsb_hold.sv */
// Low-bit holder for a group of 10-bit readings with freeze-until-read.
// Assumes the converter stops updating high bytes while frozen_out is high.
module amt_lsb_hold #(
    parameter int unsigned CH = 2
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic update_in,
    input wire logic [2*CH-1:0] low_in,
    input wire logic reg_read_in,
    input wire logic [CH-1:0] hi_read_in,
    output logic [2*CH-1:0] low_out,
    output logic frozen_out
);
    logic [CH-1:0] pending;
    logic [CH-1:0] next_pending;
    logic [2*CH-1:0] next_low;
    logic next_frozen;

    always_comb begin
        next_pending = pending & ~hi_read_in;
        // A new low-byte read re-arms even if a high byte is read now
        if (reg_read_in) begin
            next_pending = {CH{1'b1}};
        end
        next_frozen = |next_pending;
        next_low = low_out;
        if (update_in && !frozen_out && !reg_read_in) begin
            next_low = low_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pending <= '0;
            low_out <= '0;
            frozen_out <= 1'b0;
        end else begin
            pending <= next_pending;
            low_out <= next_low;
            frozen_out <= next_frozen;
        end
    end
endmodule : amt_lsb_hold

/* File: verif/amt_top_sva.sv */
// Port assertions for amt_top: register port, alert, tach tick, timer.
// Assumes it is bound to amt_top with the instance's tach period.
module amt_top_sva
    import amt_pkg::*;
#(
    parameter int unsigned TACH_SLOW_CYC = 40
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] status1_flags_in,
    input wire logic [7:0] status2_flags_in,
    input wire logic timer_event_clr_in,
    input wire logic fan4_is_overtemp_in,
    input wire logic overtemp_pin_n_in,
    input wire logic alert_out,
    input wire logic alert_pin_oe_out,
    input wire logic second_pulse_is_alert_out,
    input wire logic fan_full_speed_out,
    input wire logic tach_fast_out,
    input wire logic tach_meas_tick_out,
    input wire logic timer_event_out,
    input wire logic volt_frozen_out
);
    localparam int TSLOW = TACH_SLOW_CYC;
    localparam int TFAST = TACH_SLOW_CYC / 4;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    sequence rd_of(a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    // Rate must be settled for one cycle before the tick for the gap to be exact
    sequence tick_at(f);
        tach_meas_tick_out && tach_fast_out == f && $past(tach_fast_out) == f;
    endsequence
    mask_two_ro_a: assert property (
        rd_of(AMT_ADDR_MASK_TWO) |=> !reg_rdata_out[1]
    ) else $error("mask two bit 1 read as set");
    volt_read_a: assert property (
        rd_of(AMT_ADDR_VOLT_LOW) |=> reg_rdata_out[7:6] == 2'h0 &&
            reg_rdata_out[3:2] == 2'h0 && volt_frozen_out
    ) else $error("voltage low bits read wrong or not frozen");
    temp_read_a: assert property (
        rd_of(AMT_ADDR_TEMP_LOW) |=> reg_rdata_out[1:0] == 2'h0
    ) else $error("temperature low register bits 1:0 set");
    cfg_follow_a: assert property (
        reg_wr_in && reg_addr_in == AMT_ADDR_CONFIG |=>
            tach_fast_out == $past(reg_wdata_in[AMT_CFG_FAST_BIT]) &&
            second_pulse_is_alert_out == $past(reg_wdata_in[0])
    ) else $error("config outputs do not follow write");
    alert_quiet_a: assert property (
        status1_flags_in == 8'h00 && status2_flags_in == 8'h00 &&
            !timer_event_out |=> !alert_out
    ) else $error("alert with no flag set");
    pin_oe_a: assert property (
        !$past(second_pulse_is_alert_out) |-> !alert_pin_oe_out
    ) else $error("alert pin driven while not configured");
    boost_cause_a: assert property (
        fan_full_speed_out |->
            $past(!overtemp_pin_n_in && fan4_is_overtemp_in)
    ) else $error("full speed without overtemp input");
    timer_cause_a: assert property (
        $rose(timer_event_out) |->
            $past(!overtemp_pin_n_in && fan4_is_overtemp_in)
    ) else $error("timer event without overtemp input");
    timer_sticky_a: assert property (
        timer_event_out && !timer_event_clr_in |=> timer_event_out
    ) else $error("timer event dropped without clear");
    tick_fast_a: assert property (
        tick_at(1'b1) |-> ##TFAST (tach_meas_tick_out || !tach_fast_out)
    ) else $error("fast tach period wrong");
    tick_slow_a: assert property (
        tick_at(1'b0) |-> ##TSLOW (tach_meas_tick_out || tach_fast_out)
    ) else $error("slow tach period wrong");
endmodule : amt_top_sva

/* File: verif/amt_host.sv */
// Host model on the byte register port: single writes and reads.
// Assumes one-cycle read latency; strobes are one-cycle pulses.
module amt_host (
    input wire logic clk_sys_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        // Stale data must not look valid once released
        wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        #1;
        d = rvalid_in ? rdata_in : 8'hXX;
    endtask : rd
endmodule : amt_host

/* File: verif/test_alert_mask_and_overtemp_timer.sv */
// Bench for amt_top: registers, alert masks, low bits, overtemp timer.
// Assumes short timing: 10-cycle timer step, 40-cycle tach period.
module test_alert_mask_and_overtemp_timer
    import amt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned STEP = 10;
    localparam int unsigned TSLOW = 40;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic reg_wr_in, reg_rd_in, reg_rvalid_out;
    logic [7:0] status1_flags_in = 8'h00;
    logic [7:0] status2_flags_in = 8'h00;
    logic timer_event_clr_in = 1'b0;
    logic fan4_is_overtemp_in = 1'b0;
    logic overtemp_pin_n_in = 1'b1;
    logic adc_update_in = 1'b0;
    logic [3:0] volt_low_in = 4'h0;
    logic [5:0] temp_low_in = 6'h00;
    logic [4:0] hi_read_in = 5'h00;
    logic alert_out, alert_pin_oe_out, second_pulse_is_alert_out;
    logic fan_full_speed_out, tach_fast_out, tach_meas_tick_out;
    logic timer_event_out, volt_frozen_out, temp_frozen_out;
    logic [AMT_FANS-1:0] tach_continuous_out;
    logic [7:0] cfg_view, ot_view;
    logic [7:0] rst_regs [7] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h73,
        8'h80};
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    assign cfg_view = {tach_continuous_out, tach_fast_out, 2'h0,
        second_pulse_is_alert_out};
    assign ot_view = {5'h00, fan_full_speed_out, timer_event_out, alert_out};
    always #5 clk_sys_in = ~clk_sys_in;
    amt_top #(.STEP_CYC(STEP), .TACH_SLOW_CYC(TSLOW)) uut (
        .clk_sys_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
        .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .status1_flags_in,
        .status2_flags_in, .timer_event_clr_in, .fan4_is_overtemp_in,
        .overtemp_pin_n_in, .adc_update_in, .volt_low_in, .temp_low_in,
        .hi_read_in, .alert_out, .alert_pin_oe_out,
        .second_pulse_is_alert_out, .fan_full_speed_out, .tach_fast_out,
        .tach_continuous_out, .tach_meas_tick_out, .timer_event_out,
        .volt_frozen_out, .temp_frozen_out
    );
    amt_host host (
        .clk_sys_in, .addr_out(reg_addr_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .wdata_out(reg_wdata_in),
        .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out)
    );
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check(d, exp);
    endtask : rchk
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : cycles
    task automatic alert_chk(input logic e);
        cycles(2);
        #1;
        check({6'h00, alert_pin_oe_out, alert_out}, {6'h00, e, e});
    endtask : alert_chk
    task automatic pulse_hi(input logic [4:0] m);
        @(posedge clk_sys_in);
        hi_read_in <= m;
        @(posedge clk_sys_in);
        hi_read_in <= 5'h00;
        #1;
    endtask : pulse_hi
    task automatic adc(input logic [3:0] v, input logic [5:0] t);
        @(posedge clk_sys_in);
        volt_low_in <= v;
        temp_low_in <= t;
        adc_update_in <= 1'b1;
        @(posedge clk_sys_in);
        adc_update_in <= 1'b0;
    endtask : adc
    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        while (tach_meas_tick_out !== 1'b1 && n < 200) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end while (tach_meas_tick_out !== 1'b1 && n < 200);
        check(8'(n), 8'(exp));
    endtask : tick_gap
    task automatic set_pin(input logic v);
        @(posedge clk_sys_in);
        overtemp_pin_n_in <= v;
    endtask : set_pin
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        cycles(2);
        rstn_in <= 1'b1;
        foreach (rst_regs[i]) rchk(rst_regs[i], 8'h00);
        $display("reset values done");
        host.wr(AMT_ADDR_MASK_ONE, 8'hFF);
        rchk(AMT_ADDR_MASK_ONE, 8'hFF);
        host.wr(AMT_ADDR_MASK_TWO, 8'hFF);
        rchk(AMT_ADDR_MASK_TWO, 8'hFD);
        host.wr(AMT_ADDR_OT_TIME, 8'hFF);
        rchk(AMT_ADDR_OT_TIME, 8'h00);
        host.wr(AMT_ADDR_CONFIG, 8'hF9);
        // Config outputs update on the write's own edge; let them settle
        #1;
        check(cfg_view, 8'hF9);
        tick_gap(TSLOW / 4);
        host.wr(AMT_ADDR_CONFIG, 8'h01);
        rchk(AMT_ADDR_CONFIG, 8'h01);
        check(cfg_view, 8'h01);
        tick_gap(TSLOW);
        $display("register access done");
        host.wr(AMT_ADDR_MASK_ONE, 8'h00);
        host.wr(AMT_ADDR_MASK_TWO, 8'h00);
        for (int b = 0; b < 8; b++) begin
            if (AMT_M1_CHANNELS[b]) begin
                @(posedge clk_sys_in);
                status1_flags_in <= 8'h01 << b;
                alert_chk(1'b1);
                host.wr(AMT_ADDR_MASK_ONE, 8'h01 << b);
                alert_chk(1'b0);
                host.wr(AMT_ADDR_MASK_ONE, 8'h00);
            end
        end
        @(posedge clk_sys_in);
        status1_flags_in <= 8'h00;
        for (int b = 0; b < 8; b++) begin
            @(posedge clk_sys_in);
            status2_flags_in <= 8'h01 << b;
            alert_chk(1'b1);
            host.wr(AMT_ADDR_MASK_TWO, 8'h01 << b);
            alert_chk(b == 1);
            host.wr(AMT_ADDR_MASK_TWO, 8'h00);
            host.wr(AMT_ADDR_MASK_ONE, 8'h80);
            alert_chk(1'b0);
            host.wr(AMT_ADDR_MASK_ONE, 8'h00);
        end
        @(posedge clk_sys_in);
        status2_flags_in <= 8'h00;
        $display("alert masks done");
        adc(4'h9, 6'h39);
        rchk(AMT_ADDR_VOLT_LOW, 8'h21);
        rchk(AMT_ADDR_TEMP_LOW, 8'hE4);
        pulse_hi(5'h01);
        check({6'h00, volt_frozen_out, temp_frozen_out}, 8'h03);
        adc(4'h6, 6'h06);
        pulse_hi(5'h02);
        check({6'h00, volt_frozen_out, temp_frozen_out}, 8'h01);
        rchk(AMT_ADDR_VOLT_LOW, 8'h21);
        pulse_hi(5'h1C);
        check({6'h00, volt_frozen_out, temp_frozen_out}, 8'h02);
        adc(4'h6, 6'h06);
        rchk(AMT_ADDR_TEMP_LOW, 8'h18);
        $display("low bits done");
        host.wr(AMT_ADDR_CONFIG, 8'h05);
        host.wr(AMT_ADDR_OT_LIMIT, 8'h00);
        @(posedge clk_sys_in);
        fan4_is_overtemp_in <= 1'b1;
        set_pin(1'b0);
        cycles(3);
        #1;
        check(ot_view, 8'h00);
        rchk(AMT_ADDR_OT_TIME, 8'h00);
        set_pin(1'b1);
        host.wr(AMT_ADDR_CONFIG, 8'h07);
        set_pin(1'b0);
        cycles(3);
        #1;
        check(ot_view, 8'h07);
        host.wr(AMT_ADDR_MASK_TWO, 8'h20);
        alert_chk(1'b0);
        cycles(5 * STEP - 2);
        overtemp_pin_n_in <= 1'b1;
        rchk(AMT_ADDR_OT_TIME, 8'h05);
        rchk(AMT_ADDR_OT_TIME, 8'h00);
        check(ot_view, 8'h02);
        set_pin(1'b0);
        cycles(5);
        overtemp_pin_n_in <= 1'b1;
        rchk(AMT_ADDR_OT_TIME, 8'h01);
        @(posedge clk_sys_in);
        timer_event_clr_in <= 1'b1;
        @(posedge clk_sys_in);
        timer_event_clr_in <= 1'b0;
        host.wr(AMT_ADDR_OT_LIMIT, 8'h03);
        host.wr(AMT_ADDR_MASK_TWO, 8'h00);
        set_pin(1'b0);
        cycles(STEP + 2);
        rchk(AMT_ADDR_OT_TIME, 8'h01);
        cycles(STEP - 2);
        #1;
        check(ot_view, 8'h04);
        cycles(STEP + 4);
        overtemp_pin_n_in <= 1'b1;
        #1;
        check(ot_view, 8'h07);
        rchk(AMT_ADDR_OT_TIME, 8'h03);
        $display("overtemp timer done");
        report_and_stop();
    end
endmodule : test_alert_mask_and_overtemp_timer

bind amt_top amt_top_sva #(.TACH_SLOW_CYC(TACH_SLOW_CYC)) chk (
    .clk_sys_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .status1_flags_in, .status2_flags_in,
    .timer_event_clr_in, .fan4_is_overtemp_in, .overtemp_pin_n_in,
    .alert_out, .alert_pin_oe_out, .second_pulse_is_alert_out,
    .fan_full_speed_out, .tach_fast_out, .tach_meas_tick_out,
    .timer_event_out, .volt_frozen_out
);
